// ---- hw/tabc_pkg.sv ----
package tabc_pkg;

  // counter width and the values a read shows at the reload instant
  localparam int TABC_CNT_W = 16;
  localparam logic [15:0] TABC_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] TABC_ALL_ZEROS = 16'h0000;
  localparam logic [15:0] TABC_ONE = 16'h0001;

  // reset values
  localparam logic [15:0] TABC_CNT_RST = 16'h0000;
  localparam logic [15:0] TABC_RELOAD_RST = 16'h0000;
  localparam logic [15:0] TABC_RDATA_RST = 16'h0000;

  // synchroniser lanes: bit positions of the pin inputs
  localparam int TABC_SYNC_W = 2;
  localparam int TABC_SYNC_A_EVENT = 0;
  localparam int TABC_SYNC_B_EVENT = 1;

  // family A operating modes
  typedef enum logic [1:0] {
    TABC_A_TIMER,
    TABC_A_EVENT,
    TABC_A_ONESHOT,
    TABC_A_PWM
  } tabc_a_mode_t;

  // family B operating modes
  typedef enum logic [1:0] {
    TABC_B_TIMER,
    TABC_B_EVENT,
    TABC_B_MEASURE
  } tabc_b_mode_t;

  // family A control bits, held by software
  typedef struct packed {
    tabc_a_mode_t mode;
    logic start;
    logic count_up;
    logic free_run;
  } tabc_a_ctrl_t;

  // family B control bits; width_sel is the measurement mode select bit
  typedef struct packed {
    tabc_b_mode_t mode;
    logic start;
    logic width_sel;
  } tabc_b_ctrl_t;

endpackage

// ---- hw/tabc_sync.sv ----
`timescale 1ns/1ps
module tabc_sync
  import tabc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // asynchronous levels and their synchronised copies
  input wire logic [TABC_SYNC_W-1:0] async_in,
  output logic [TABC_SYNC_W-1:0] sync_out
);

  logic [TABC_SYNC_W-1:0] meta;

  // two stages per lane; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < TABC_SYNC_W; i = i + 1) begin : g_lane
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// ---- hw/tabc_timer.sv ----
`timescale 1ns/1ps
module tabc_timer
  import tabc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // family A control and register access
  input wire tabc_a_ctrl_t ta_ctrl_in,
  input wire logic ta_wr_in,
  input wire logic [TABC_CNT_W-1:0] ta_wdata_in,
  input wire logic ta_rd_in,
  input wire logic ta_irq_clr_in,
  input wire logic ta_event_in,
  // family B control and register access
  input wire tabc_b_ctrl_t tb_ctrl_in,
  input wire logic tb_wr_in,
  input wire logic [TABC_CNT_W-1:0] tb_wdata_in,
  input wire logic tb_rd_in,
  input wire logic tb_irq_clr_in,
  input wire logic tb_event_in,
  // family A results
  output logic [TABC_CNT_W-1:0] ta_rdata_out,
  output logic ta_irq_out,
  output logic timer_a_output_pin_out,
  // family B results
  output logic [TABC_CNT_W-1:0] tb_rdata_out,
  output logic tb_irq_out
);

  logic rst_meta;
  logic rst_n;
  logic [TABC_SYNC_W-1:0] pin_sync;
  logic a_ev_q;
  logic b_ev_q;
  logic a_ev_rise;
  logic b_ev_rise;
  logic b_ev_edge;

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  tabc_sync u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .async_in({tb_event_in, ta_event_in}),
    .sync_out(pin_sync)
  );

  // edge detection on the synchronised copies only
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      a_ev_q <= 1'b0;
      b_ev_q <= 1'b0;
    end else begin
      a_ev_q <= pin_sync[TABC_SYNC_A_EVENT];
      b_ev_q <= pin_sync[TABC_SYNC_B_EVENT];
    end
  end

  assign a_ev_rise = pin_sync[TABC_SYNC_A_EVENT] & ~a_ev_q;
  assign b_ev_rise = pin_sync[TABC_SYNC_B_EVENT] & ~b_ev_q;
  assign b_ev_edge = pin_sync[TABC_SYNC_B_EVENT] ^ b_ev_q;

  // ---------------- family A ----------------
  logic [TABC_CNT_W-1:0] a_cnt;
  logic [TABC_CNT_W-1:0] a_reload;
  tabc_a_mode_t a_mode_q;
  logic a_start_q;
  logic a_os_active;
  logic a_pwm_high;
  logic a_start_rise;
  logic a_start_fall;
  logic a_counting;
  logic a_tick;
  logic a_down;
  logic a_terminal;
  logic a_reload_now;
  logic a_wrap;
  logic a_enter_irq_mode;
  logic a_irq_set;

  assign a_start_rise = ta_ctrl_in.start & ~a_start_q;
  assign a_start_fall = a_start_q & ~ta_ctrl_in.start;

  // one-shot runs on its own trigger; the other modes follow the start flag
  always_comb begin
    a_counting = ta_ctrl_in.start;
    a_tick = 1'b1;
    a_down = 1'b1;
    case (ta_ctrl_in.mode)
      TABC_A_TIMER: begin
        a_counting = ta_ctrl_in.start;
      end
      TABC_A_EVENT: begin
        a_tick = a_ev_rise;
        a_down = ~ta_ctrl_in.count_up;
      end
      TABC_A_ONESHOT: begin
        a_counting = a_os_active & ta_ctrl_in.start;
      end
      default: begin
        a_counting = ta_ctrl_in.start & a_start_q;
      end
    endcase
  end

  assign a_terminal = a_down ? (a_cnt == TABC_ALL_ZEROS) : (a_cnt == TABC_ALL_ONES);
  // free-running event counting wraps with no reload instant
  assign a_wrap = a_counting & a_tick & a_terminal;
  assign a_reload_now = a_wrap & ~((ta_ctrl_in.mode == TABC_A_EVENT) & ta_ctrl_in.free_run);

  // only entries from timer or event count; reset leaves the mode at timer
  assign a_enter_irq_mode = (ta_ctrl_in.mode != a_mode_q) &
                            ((ta_ctrl_in.mode == TABC_A_ONESHOT) |
                             (ta_ctrl_in.mode == TABC_A_PWM)) &
                            ((a_mode_q == TABC_A_TIMER) | (a_mode_q == TABC_A_EVENT));

  // mode and start history
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      a_mode_q <= TABC_A_TIMER;
      a_start_q <= 1'b0;
    end else begin
      a_mode_q <= ta_ctrl_in.mode;
      a_start_q <= ta_ctrl_in.start;
    end
  end

  // reload register follows every write; counter only takes it while halted
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      a_reload <= TABC_RELOAD_RST;
    end else if (ta_wr_in) begin
      a_reload <= ta_wdata_in;
    end
  end

  // family A counter
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      a_cnt <= TABC_CNT_RST;
    end else if (ta_wr_in && !a_counting) begin
      a_cnt <= ta_wdata_in;
    end else if ((ta_ctrl_in.mode == TABC_A_ONESHOT) && a_os_active && a_start_fall) begin
      a_cnt <= a_reload;
    end else if ((ta_ctrl_in.mode == TABC_A_PWM) && a_start_rise) begin
      a_cnt <= a_reload;
    end else if (a_reload_now) begin
      if (ta_ctrl_in.mode == TABC_A_PWM) begin
        a_cnt <= a_pwm_high ? ~a_reload : a_reload;
      end else begin
        a_cnt <= a_reload;
      end
    end else if (a_counting && a_tick) begin
      a_cnt <= a_down ? a_cnt - TABC_ONE : a_cnt + TABC_ONE;
    end
  end

  // one-shot trigger on the start edge, ended by underflow or by clearing start
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      a_os_active <= 1'b0;
    end else if (ta_ctrl_in.mode != TABC_A_ONESHOT) begin
      a_os_active <= 1'b0;
    end else if (a_start_rise) begin
      a_os_active <= 1'b1;
    end else if (a_start_fall || a_reload_now) begin
      a_os_active <= 1'b0;
    end
  end

  // pwm phase: high for the reload count, low for its complement
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      a_pwm_high <= 1'b0;
    end else if (ta_ctrl_in.mode != TABC_A_PWM) begin
      a_pwm_high <= 1'b0;
    end else if (a_start_rise) begin
      a_pwm_high <= 1'b1;
    end else if (!ta_ctrl_in.start) begin
      a_pwm_high <= 1'b0;
    end else if (a_reload_now) begin
      a_pwm_high <= ~a_pwm_high;
    end
  end

  // output pin driven from the active phase register
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      timer_a_output_pin_out <= 1'b0;
    end else begin
      case (ta_ctrl_in.mode)
        TABC_A_ONESHOT: begin
          timer_a_output_pin_out <= a_os_active & ta_ctrl_in.start & ~a_reload_now;
        end
        TABC_A_PWM: begin
          timer_a_output_pin_out <= a_pwm_high & ta_ctrl_in.start &
                                    ~(a_reload_now & a_pwm_high);
        end
        default: begin
          timer_a_output_pin_out <= 1'b0;
        end
      endcase
    end
  end

  // family A request sources
  always_comb begin
    a_irq_set = a_enter_irq_mode;
    case (ta_ctrl_in.mode)
      TABC_A_ONESHOT: begin
        a_irq_set = a_irq_set | (a_os_active & (a_start_fall | a_reload_now));
      end
      TABC_A_PWM: begin
        // a low pin at stop raises nothing
        a_irq_set = a_irq_set | (a_pwm_high & (a_start_fall | a_reload_now));
      end
      default: begin
        a_irq_set = a_irq_set | a_wrap;
      end
    endcase
  end

  // sticky request; a set in the clearing cycle wins
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ta_irq_out <= 1'b0;
    end else if (a_irq_set) begin
      ta_irq_out <= 1'b1;
    end else if (ta_irq_clr_in) begin
      ta_irq_out <= 1'b0;
    end
  end

  // family A read: live count, or the fixed pattern at a timer or event mode reload instant
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ta_rdata_out <= TABC_RDATA_RST;
    end else if (ta_rd_in) begin
      if (a_reload_now && (ta_ctrl_in.mode == TABC_A_TIMER)) begin
        ta_rdata_out <= TABC_ALL_ONES;
      end else if (a_reload_now && (ta_ctrl_in.mode == TABC_A_EVENT)) begin
        ta_rdata_out <= a_down ? TABC_ALL_ONES : TABC_ALL_ZEROS;
      end else begin
        ta_rdata_out <= a_cnt;
      end
    end
  end

  // ---------------- family B ----------------
  logic [TABC_CNT_W-1:0] b_cnt;
  logic [TABC_CNT_W-1:0] b_reload;
  logic b_start_q;
  logic b_sel_q;
  logic b_first_edge;
  logic b_measure;
  logic b_tick;
  logic b_reload_now;
  logic b_meas_edge;
  logic b_sel_change;

  assign b_measure = (tb_ctrl_in.mode == TABC_B_MEASURE);
  assign b_tick = (tb_ctrl_in.mode == TABC_B_EVENT) ? b_ev_rise : 1'b1;
  assign b_reload_now = ~b_measure & tb_ctrl_in.start & b_tick & (b_cnt == TABC_ALL_ZEROS);
  // period measures rising to rising, width measures every edge
  assign b_meas_edge = b_measure & tb_ctrl_in.start & b_start_q &
                       (tb_ctrl_in.width_sel ? b_ev_edge : b_ev_rise);
  assign b_sel_change = b_measure & tb_ctrl_in.start & b_start_q &
                        (tb_ctrl_in.width_sel != b_sel_q);

  // start and select history
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      b_start_q <= 1'b0;
      b_sel_q <= 1'b0;
    end else begin
      b_start_q <= tb_ctrl_in.start;
      b_sel_q <= tb_ctrl_in.width_sel;
    end
  end

  // first edge after start is only an alignment point
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      b_first_edge <= 1'b0;
    end else if (tb_ctrl_in.start && !b_start_q) begin
      b_first_edge <= 1'b1;
    end else if (b_meas_edge) begin
      b_first_edge <= 1'b0;
    end
  end

  // reload register: software value, or the capture in measurement mode
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      b_reload <= TABC_RELOAD_RST;
    end else if (b_meas_edge) begin
      b_reload <= b_cnt;
    end else if (tb_wr_in) begin
      b_reload <= tb_wdata_in;
    end
  end

  // family B counter: down in timer and event modes, up while measuring
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      b_cnt <= TABC_CNT_RST;
    end else if (tb_wr_in && !tb_ctrl_in.start) begin
      b_cnt <= tb_wdata_in;
    end else if (b_meas_edge) begin
      b_cnt <= TABC_ALL_ZEROS;
    end else if (b_measure && tb_ctrl_in.start) begin
      b_cnt <= b_cnt + TABC_ONE;
    end else if (b_reload_now) begin
      b_cnt <= b_reload;
    end else if (tb_ctrl_in.start && b_tick) begin
      b_cnt <= b_cnt - TABC_ONE;
    end
  end

  // sticky request; a set in the clearing cycle wins
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      tb_irq_out <= 1'b0;
    end else if (b_reload_now || b_sel_change || (b_meas_edge && !b_first_edge)) begin
      tb_irq_out <= 1'b1;
    end else if (tb_irq_clr_in) begin
      tb_irq_out <= 1'b0;
    end
  end

  // family B read; measurement shows the last capture
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      tb_rdata_out <= TABC_RDATA_RST;
    end else if (tb_rd_in) begin
      if (b_reload_now) begin
        tb_rdata_out <= TABC_ALL_ONES;
      end else if (b_measure) begin
        tb_rdata_out <= b_reload;
      end else begin
        tb_rdata_out <= b_cnt;
      end
    end
  end

endmodule

// ---- sim/tabc_timer_assertions.sv ----
`timescale 1ns/1ps
module tabc_timer_assertions
  import tabc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // control levels and clear strobes
  input wire tabc_a_ctrl_t ta_ctrl_in,
  input wire logic ta_irq_clr_in,
  input wire tabc_b_ctrl_t tb_ctrl_in,
  input wire logic tb_irq_clr_in,
  // watched results
  input wire logic ta_irq_out,
  input wire logic timer_a_output_pin_out,
  input wire logic tb_irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // requests only drop on a clear strobe
  property p_a_sticky;
    ta_irq_out && !ta_irq_clr_in |=> ta_irq_out;
  endproperty
  a_a_sticky: assert property (p_a_sticky) else $error("timer a request dropped");
  property p_b_sticky;
    tb_irq_out && !tb_irq_clr_in |=> tb_irq_out;
  endproperty
  a_b_sticky: assert property (p_b_sticky) else $error("timer b request dropped");
  // entering one-shot or pwm from timer or event raises the request
  property p_oneshot_entry;
    ta_ctrl_in.mode == TABC_A_ONESHOT && $past(ta_ctrl_in.mode) inside {TABC_A_TIMER, TABC_A_EVENT}
      |-> ##[1:3] ta_irq_out;
  endproperty
  a_oneshot_entry: assert property (p_oneshot_entry) else $error("no request on one-shot");
  property p_pwm_entry;
    ta_ctrl_in.mode == TABC_A_PWM && $past(ta_ctrl_in.mode) inside {TABC_A_TIMER, TABC_A_EVENT}
      |-> ##[1:3] ta_irq_out;
  endproperty
  a_pwm_entry: assert property (p_pwm_entry) else $error("no request on pwm entry");
  // stopping mid-pulse drops the pin and raises the request
  property p_oneshot_stop;
    ta_ctrl_in.mode == TABC_A_ONESHOT && $fell(ta_ctrl_in.start) && timer_a_output_pin_out
      |-> ##[1:2] (!timer_a_output_pin_out && ta_irq_out);
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot stop wrong");
  property p_pwm_stop_high;
    ta_ctrl_in.mode == TABC_A_PWM && $fell(ta_ctrl_in.start) && timer_a_output_pin_out
      |-> ##[1:2] (!timer_a_output_pin_out && ta_irq_out);
  endproperty
  a_pwm_stop_high: assert property (p_pwm_stop_high) else $error("pwm high stop wrong");
  // low phase stop leaves pin and request alone
  property p_pwm_stop_low;
    ta_ctrl_in.mode == TABC_A_PWM && $fell(ta_ctrl_in.start) && !timer_a_output_pin_out
      && !ta_irq_out |=> (!timer_a_output_pin_out && !ta_irq_out) [*2];
  endproperty
  a_pwm_stop_low: assert property (p_pwm_stop_low) else $error("pwm low stop wrong");
  property p_width_sel;
    tb_ctrl_in.mode == TABC_B_MEASURE && tb_ctrl_in.start && $past(tb_ctrl_in.start)
      && $changed(tb_ctrl_in.width_sel) |-> ##[1:2] tb_irq_out;
  endproperty
  a_width_sel: assert property (p_width_sel) else $error("no request on select change");
endmodule

bind tabc_timer tabc_timer_assertions tabc_timer_assertions_inst (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .ta_ctrl_in(ta_ctrl_in),
  .ta_irq_clr_in(ta_irq_clr_in),
  .tb_ctrl_in(tb_ctrl_in),
  .tb_irq_clr_in(tb_irq_clr_in),
  .ta_irq_out(ta_irq_out),
  .timer_a_output_pin_out(timer_a_output_pin_out),
  .tb_irq_out(tb_irq_out)
);

// ---- sim/test_tabc_timer.sv ----
`timescale 1ns/1ps
module test_tabc_timer
  import tabc_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  tabc_a_ctrl_t ta_ctrl_in = '0;
  tabc_b_ctrl_t tb_ctrl_in = '0;
  logic ta_wr_in = 1'b0, ta_rd_in = 1'b0, ta_irq_clr_in = 1'b0, ta_event_in = 1'b0;
  logic tb_wr_in = 1'b0, tb_rd_in = 1'b0, tb_irq_clr_in = 1'b0, tb_event_in = 1'b0;
  logic [15:0] ta_wdata_in = 16'h0000, tb_wdata_in = 16'h0000, ta_rdata_out, tb_rdata_out;
  logic ta_irq_out, timer_a_output_pin_out, tb_irq_out;
  int err_total = 0;
  int check_count = 0;

  // 100 ns period
  always #50 clock_in = ~clock_in;

  tabc_timer tabc_timer_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in),
    .ta_ctrl_in(ta_ctrl_in), .ta_wr_in(ta_wr_in), .ta_wdata_in(ta_wdata_in),
    .ta_rd_in(ta_rd_in), .ta_irq_clr_in(ta_irq_clr_in), .ta_event_in(ta_event_in),
    .tb_ctrl_in(tb_ctrl_in), .tb_wr_in(tb_wr_in), .tb_wdata_in(tb_wdata_in),
    .tb_rd_in(tb_rd_in), .tb_irq_clr_in(tb_irq_clr_in), .tb_event_in(tb_event_in),
    .ta_rdata_out(ta_rdata_out), .ta_irq_out(ta_irq_out),
    .timer_a_output_pin_out(timer_a_output_pin_out),
    .tb_rdata_out(tb_rdata_out), .tb_irq_out(tb_irq_out)
  );

  // inputs move 1 ns after the edge, away from the sampling point
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input bit b, input logic [15:0] d);
    if (b) begin
      tb_wr_in = 1'b1;
      tb_wdata_in = d;
    end else begin
      ta_wr_in = 1'b1;
      ta_wdata_in = d;
    end
    tick(1);
    ta_wr_in = 1'b0;
    tb_wr_in = 1'b0;
  endtask

  // read strobe, then one extra edge so the registered data has landed
  task automatic rd_chk(input bit b, input logic [15:0] exp, input string nm);
    if (b) begin
      tb_rd_in = 1'b1;
    end else begin
      ta_rd_in = 1'b1;
    end
    tick(1);
    ta_rd_in = 1'b0;
    tb_rd_in = 1'b0;
    tick(1);
    check(nm, exp, b ? tb_rdata_out : ta_rdata_out);
  endtask

  // read every cycle; the reload value only shows for one cycle
  task automatic poll(input bit b, input logic [15:0] exp, input bit pulse, input string nm);
    logic seen;
    seen = 1'b0;
    if (b) begin
      tb_rd_in = 1'b1;
    end else begin
      ta_rd_in = 1'b1;
    end
    // pulses go to the event pin of the family being read
    for (int i = 0; i < 40; i++) begin
      if (pulse && i % 3 == 0) begin
        if (b) begin
          tb_event_in = ~tb_event_in;
        end else begin
          ta_event_in = ~ta_event_in;
        end
      end
      tick(1);
      if ((b ? tb_rdata_out : ta_rdata_out) === exp) seen = 1'b1;
    end
    ta_rd_in = 1'b0;
    tb_rd_in = 1'b0;
    check(nm, 16'h0001, {15'h0000, seen});
  endtask

  task automatic clr(input bit b);
    if (b) begin
      tb_irq_clr_in = 1'b1;
    end else begin
      ta_irq_clr_in = 1'b1;
    end
    tick(1);
    ta_irq_clr_in = 1'b0;
    tb_irq_clr_in = 1'b0;
    tick(1);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // whole sequence needs well under 1000 cycles
  initial begin
    #(3000 * 100);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    tick(3);
    // family a timer mode: halted load, then reload reads all ones
    wr(0, 16'h0002);
    rd_chk(0, 16'h0002, "a halted load");
    ta_ctrl_in.start = 1'b1;
    poll(0, TABC_ALL_ONES, 0, "a timer reload read");
    ta_ctrl_in.start = 1'b0;
    tick(2);
    check("a irq held", 16'h0001, {15'h0000, ta_irq_out});
    clr(0);
    check("a irq cleared", 16'h0000, {15'h0000, ta_irq_out});
    // live read: three clocks after start the count is 0x10 less three
    wr(0, 16'h0010);
    ta_ctrl_in.start = 1'b1;
    tick(3);
    rd_chk(0, 16'h000D, "a live read");
    ta_ctrl_in.start = 1'b0;
    tick(1);
    // event mode, down then up
    ta_ctrl_in.mode = TABC_A_EVENT;
    wr(0, 16'h0001);
    ta_ctrl_in.start = 1'b1;
    poll(0, TABC_ALL_ONES, 1, "a underflow read");
    ta_ctrl_in.start = 1'b0;
    ta_ctrl_in.count_up = 1'b1;
    tick(1);
    wr(0, 16'hFFFE);
    ta_ctrl_in.start = 1'b1;
    poll(0, TABC_ALL_ZEROS, 1, "a overflow read");
    ta_ctrl_in.start = 1'b0;
    ta_ctrl_in.count_up = 1'b0;
    tick(2);
    clr(0);
    // free-running wrap: no reload, so the count runs on past all ones
    ta_ctrl_in.free_run = 1'b1;
    wr(0, 16'h0001);
    ta_ctrl_in.start = 1'b1;
    poll(0, 16'hFFFE, 1, "a free run wrap");
    ta_ctrl_in.start = 1'b0;
    tick(1);
    check("a free run irq", 16'h0001, {15'h0000, ta_irq_out});
    ta_ctrl_in.free_run = 1'b0;
    wr(0, 16'h0005);
    rd_chk(0, 16'h0005, "a rewrite after stop");
    clr(0);
    // family b timer mode
    wr(1, 16'h0002);
    rd_chk(1, 16'h0002, "b halted load");
    tb_ctrl_in.start = 1'b1;
    poll(1, TABC_ALL_ONES, 0, "b reload read");
    tb_ctrl_in.start = 1'b0;
    tick(1);
    // family b event mode reload read
    tb_ctrl_in.mode = TABC_B_EVENT;
    wr(1, 16'h0001);
    tb_ctrl_in.start = 1'b1;
    poll(1, TABC_ALL_ONES, 1, "b event reload read");
    tb_ctrl_in.start = 1'b0;
    tick(2);
    clr(1);
    // one-shot entry from event mode, then stop mid-count
    ta_ctrl_in.mode = TABC_A_ONESHOT;
    tick(3);
    check("oneshot entry irq", 16'h0001, {15'h0000, ta_irq_out});
    clr(0);
    wr(0, 16'h0064);
    ta_ctrl_in.start = 1'b1;
    tick(4);
    check("oneshot pin", 16'h0001, {15'h0000, timer_a_output_pin_out});
    ta_ctrl_in.start = 1'b0;
    tick(3);
    check("oneshot stop", 16'h0001, {15'h0000, ~timer_a_output_pin_out & ta_irq_out});
    rd_chk(0, 16'h0064, "oneshot reloaded");
    // pwm entry from timer mode
    ta_ctrl_in.mode = TABC_A_TIMER;
    tick(2);
    clr(0);
    ta_ctrl_in.mode = TABC_A_PWM;
    tick(3);
    check("pwm entry irq", 16'h0001, {15'h0000, ta_irq_out});
    clr(0);
    wr(0, 16'h0064);
    ta_ctrl_in.start = 1'b1;
    tick(4);
    ta_ctrl_in.start = 1'b0;
    tick(3);
    check("pwm high stop", 16'h0001, {15'h0000, ~timer_a_output_pin_out & ta_irq_out});
    clr(0);
    // short high phase, stop during the long low phase
    wr(0, 16'h0003);
    ta_ctrl_in.start = 1'b1;
    tick(12);
    clr(0);
    ta_ctrl_in.start = 1'b0;
    tick(3);
    check("pwm low stop", 16'h0000, {15'h0000, timer_a_output_pin_out | ta_irq_out});
    // family b measurement: first edge silent, second raises
    tb_ctrl_in.mode = TABC_B_MEASURE;
    tick(2);
    clr(1);
    tb_ctrl_in.start = 1'b1;
    tick(3);
    tb_event_in = 1'b1;
    tick(6);
    check("first edge irq", 16'h0000, {15'h0000, tb_irq_out});
    tb_event_in = 1'b0;
    tick(3);
    tb_event_in = 1'b1;
    tick(6);
    check("second edge irq", 16'h0001, {15'h0000, tb_irq_out});
    clr(1);
    tb_ctrl_in.width_sel = 1'b1;
    tick(3);
    check("select change irq", 16'h0001, {15'h0000, tb_irq_out});
    give_verdict();
  end
endmodule
